//--- src/modbus_slave_function_handler.sv
// slave function-code interpreter: parses requests, drives register port, builds answers
// Notes on behaviour
// RULE_01: only codes 03h, 04h, 05h, 06h, 10h are accepted; others are unsupported.
// RULE_02: codes 03h and 04h behave the same, reading consecutive registers.
// RULE_03: starting address alone picks settings versus actual values; the code compares each register's own address with SETTING_BASE.
// RULE_04: registers are 16 bits, sent high byte then low byte.
// RULE_05: a read may ask for at most 125 registers.
// RULE_06: read request is address, code, start hi/lo, count hi/lo, check-sum.
// RULE_07: read answer is address, code, byte count, register pairs, check-sum.
// RULE_08: check-sum goes low byte first, high byte last.
// RULE_09: execute request carries operation code then code value FF 00.
// RULE_10: execute request is echoed back unchanged.
// RULE_11: operation 0000 nothing, 0001 reset, 0005 clear events, 0006 clear oscillography.
// RULE_12: operations 1000 to 101F switch virtual inputs 1 to 32.
// RULE_13: store-single writes one register and echoes the whole request.
// RULE_14: store-multiple writes consecutive registers, at most 60.
// RULE_15: store-multiple request adds a count and byte count before data.
// RULE_16: store-multiple answer echoes address, code, start, count, new check-sum.
// RULE_17: bad data or unsupported code answers code with top bit set plus error.
// RULE_18: received packet with its check-sum divides to a zero remainder.
// RULE_19: a packet ends after three and a half idle byte times.
// RULE_20: only packets for our address with a good check-sum are handled.
// RULE_21: requests whose counts disagree with packet length are dropped silently.
module modbus_slave_function_handler #(
  parameter int unsigned GAP_CYCLES = modbus_slave_pkg::GAP_CYCLES,
  parameter logic [15:0] SETTING_BASE = modbus_slave_pkg::SETTING_BASE
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] own_address,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_setting,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  output logic op_reset,
  output logic op_clear_events,
  output logic op_clear_oscillo,
  output logic [31:0] virt_in
);
  localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
  localparam logic [GW-1:0] GAP_LAST = GW'(GAP_CYCLES - 1);

  typedef enum logic [3:0] {
    S_RX, S_CHECK, S_EXEC, S_WRITE, S_HDR, S_RD_REQ, S_RD_CAP, S_RD_HI, S_RD_LO,
    S_CRC_LO, S_CRC_HI
  } state_t;

  typedef struct packed {
    state_t st;
    logic [8:0] len;
    logic [GW-1:0] gap;
    logic [15:0] crc;
    logic [7:0] idx;
    logic [2:0] hlen;
    logic [7:0] fn_out;
    logic [7:0] exc;
    logic [6:0] cnt;
    logic [6:0] i;
    logic [15:0] addr;
    logic [15:0] data;
    logic push;
    logic [7:0] txb;
    logic rd;
    logic wr;
    logic setting;
    logic [15:0] raddr;
    logic [15:0] wdata;
    logic op_rst;
    logic op_evt;
    logic op_osc;
    logic [31:0] vin;
  } hs_t;

  localparam logic [8:0] LEN_MAX = modbus_slave_pkg::LEN_MAX;

  hs_t s_q, s_d;
  logic [7:0] rxbuf [0:255];
  logic buf_in_ready;
  logic rx_store;

  assign rx_store = (s_q.st == S_RX) && rx_valid && (s_q.len < LEN_MAX);

  // request bytes kept for parsing and echo; no reset needed on data
  always_ff @(posedge mclk) begin
    if (rx_store) begin
      rxbuf[s_q.len[7:0]] <= rx_data;
    end
  end

  always_comb begin
    logic free;
    logic [7:0] fn;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0] hb;
    fn = rxbuf[1];
    start = {rxbuf[2], rxbuf[3]};
    count = {rxbuf[4], rxbuf[5]};
    hb = 8'h00;
    free = !s_q.push || buf_in_ready;
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.wr = 1'b0;
    s_d.op_rst = 1'b0;
    s_d.op_evt = 1'b0;
    s_d.op_osc = 1'b0;
    if (buf_in_ready) begin
      s_d.push = 1'b0;
    end
    case (s_q.st)
      S_RX: begin
        if (rx_valid) begin
          s_d.gap = '0;
          s_d.crc = modbus_slave_pkg::crc16_byte(s_q.crc, rx_data); // RULE_18
          if (s_q.len < LEN_MAX) begin
            s_d.len = s_q.len + 9'h001;
          end
        end else if (s_q.len != 9'h000) begin
          if (s_q.gap == GAP_LAST) begin
            s_d.st = S_CHECK; // RULE_19
          end else begin
            s_d.gap = s_q.gap + GW'(1);
          end
        end
      end
      S_CHECK: begin
        s_d.st = S_RX;
        s_d.len = 9'h000;
        s_d.gap = '0;
        s_d.crc = modbus_slave_pkg::CRC_INIT;
        s_d.idx = 8'h00;
        s_d.i = 7'h00;
        s_d.exc = 8'h00;
        s_d.fn_out = fn;
        s_d.addr = start;
        s_d.cnt = count[6:0];
        s_d.hlen = modbus_slave_pkg::HDR_ECHO;
        // overlong frames never fit a legal request, so they are dropped
        if (s_q.len >= 9'h004 && s_q.len < LEN_MAX && rxbuf[0] == own_address
            && s_q.crc == 16'h0000) begin // RULE_20
          case (fn)
            modbus_slave_pkg::FN_READ_HOLD, modbus_slave_pkg::FN_READ_INPUT: begin // RULE_02
              if (s_q.len == modbus_slave_pkg::LEN_FIXED) begin // RULE_06 RULE_21
                s_d.st = S_HDR;
                s_d.hlen = modbus_slave_pkg::HDR_SHORT;
                if (count == 16'h0000 || count > modbus_slave_pkg::MAX_READ_REGS) begin // RULE_05
                  s_d.exc = modbus_slave_pkg::EXC_BAD_VALUE;
                end
              end
            end
            modbus_slave_pkg::FN_EXECUTE: begin
              if (s_q.len == modbus_slave_pkg::LEN_FIXED) begin // RULE_21
                s_d.st = S_EXEC;
              end
            end
            modbus_slave_pkg::FN_STORE_ONE: begin
              if (s_q.len == modbus_slave_pkg::LEN_FIXED) begin // RULE_21
                s_d.st = S_WRITE;
                s_d.cnt = 7'h01;
                s_d.idx = modbus_slave_pkg::POS_DATA_ONE;
              end
            end
            modbus_slave_pkg::FN_STORE_MANY: begin
              if (s_q.len == modbus_slave_pkg::LEN_STORE_HDR + {1'b0, rxbuf[6]}
                  && {count[14:0], 1'b0} == {8'h00, rxbuf[6]}) begin // RULE_15 RULE_21
                s_d.st = S_WRITE;
                s_d.idx = modbus_slave_pkg::POS_DATA_MANY;
                if (count == 16'h0000 || count > modbus_slave_pkg::MAX_STORE_REGS) begin // RULE_14
                  s_d.st = S_HDR;
                  s_d.idx = 8'h00;
                  s_d.exc = modbus_slave_pkg::EXC_BAD_VALUE;
                end
              end
            end
            default: begin
              s_d.st = S_HDR; // RULE_01
              s_d.exc = modbus_slave_pkg::EXC_BAD_FUNCTION;
            end
          endcase
        end
        if (s_d.exc != 8'h00) begin
          s_d.hlen = modbus_slave_pkg::HDR_SHORT;
          s_d.fn_out = fn | modbus_slave_pkg::EXC_FLAG; // RULE_17
        end
      end
      S_EXEC: begin
        s_d.st = S_HDR;
        s_d.idx = 8'h00;
        if ({rxbuf[4], rxbuf[5]} != modbus_slave_pkg::CODE_ON
            && {rxbuf[4], rxbuf[5]} != modbus_slave_pkg::CODE_OFF) begin // RULE_09
          s_d.exc = modbus_slave_pkg::EXC_BAD_VALUE;
        end else if (start >= modbus_slave_pkg::OP_VIRT_FIRST
                     && start <= modbus_slave_pkg::OP_VIRT_LAST) begin
          s_d.vin[start[4:0]] = ({rxbuf[4], rxbuf[5]} == modbus_slave_pkg::CODE_ON); // RULE_12
        end else begin
          case (start) // RULE_11
            modbus_slave_pkg::OP_NONE: s_d.op_rst = 1'b0;
            modbus_slave_pkg::OP_RESET: s_d.op_rst = 1'b1;
            modbus_slave_pkg::OP_CLEAR_EVENTS: s_d.op_evt = 1'b1;
            modbus_slave_pkg::OP_CLEAR_OSCILLO: s_d.op_osc = 1'b1;
            default: s_d.exc = modbus_slave_pkg::EXC_BAD_ADDRESS;
          endcase
        end
        if (s_d.exc != 8'h00) begin
          s_d.hlen = modbus_slave_pkg::HDR_SHORT;
          s_d.fn_out = fn | modbus_slave_pkg::EXC_FLAG; // RULE_17
        end
      end
      S_WRITE: begin
        s_d.wr = 1'b1; // RULE_13
        s_d.raddr = s_q.addr;
        s_d.setting = (s_q.addr >= SETTING_BASE); // RULE_03
        s_d.wdata = {rxbuf[s_q.idx], rxbuf[s_q.idx + 8'h01]}; // RULE_04
        s_d.addr = s_q.addr + 16'h0001;
        s_d.idx = s_q.idx + 8'h02;
        s_d.i = s_q.i + 7'h01;
        if (s_q.i + 7'h01 == s_q.cnt) begin // RULE_14
          s_d.st = S_HDR;
          s_d.idx = 8'h00;
        end
      end
      S_HDR: begin
        if (free) begin
          // header is an echo of the request except code and third byte
          if (s_q.idx == 8'h01) begin
            hb = s_q.fn_out;
          end else if (s_q.idx == 8'h02 && s_q.exc != 8'h00) begin
            hb = s_q.exc; // RULE_17
          end else if (s_q.idx == 8'h02 && s_q.hlen == modbus_slave_pkg::HDR_SHORT) begin
            hb = {s_q.cnt, 1'b0}; // RULE_07
          end else begin
            hb = rxbuf[s_q.idx]; // RULE_10 RULE_13 RULE_16
          end
          s_d.push = 1'b1;
          s_d.txb = hb;
          s_d.crc = modbus_slave_pkg::crc16_byte(s_q.crc, hb);
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.idx + 8'h01 == {5'h00, s_q.hlen}) begin
            s_d.st = (s_q.hlen == modbus_slave_pkg::HDR_SHORT && s_q.exc == 8'h00)
                     ? S_RD_REQ : S_CRC_LO;
          end
        end
      end
      S_RD_REQ: begin
        s_d.rd = 1'b1;
        s_d.raddr = s_q.addr;
        s_d.setting = (s_q.addr >= SETTING_BASE); // RULE_03
        s_d.st = S_RD_CAP;
      end
      S_RD_CAP: begin
        // register port answers one cycle after the strobe
        if (!s_q.rd) begin
          s_d.data = reg_rdata;
          s_d.addr = s_q.addr + 16'h0001;
          s_d.st = S_RD_HI;
        end
      end
      S_RD_HI: begin
        if (free) begin
          s_d.push = 1'b1;
          s_d.txb = s_q.data[15:8]; // RULE_04
          s_d.crc = modbus_slave_pkg::crc16_byte(s_q.crc, s_q.data[15:8]);
          s_d.st = S_RD_LO;
        end
      end
      S_RD_LO: begin
        if (free) begin
          s_d.push = 1'b1;
          s_d.txb = s_q.data[7:0];
          s_d.crc = modbus_slave_pkg::crc16_byte(s_q.crc, s_q.data[7:0]);
          s_d.i = s_q.i + 7'h01;
          s_d.st = (s_q.i + 7'h01 == s_q.cnt) ? S_CRC_LO : S_RD_REQ; // RULE_07
        end
      end
      S_CRC_LO: begin
        if (free) begin
          s_d.push = 1'b1;
          s_d.txb = s_q.crc[7:0]; // RULE_08
          s_d.st = S_CRC_HI;
        end
      end
      S_CRC_HI: begin
        if (free) begin
          s_d.push = 1'b1;
          s_d.txb = s_q.crc[15:8]; // RULE_08
          s_d.crc = modbus_slave_pkg::CRC_INIT;
          s_d.st = S_RX;
        end
      end
      default: s_d.st = S_RX;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: S_RX, crc: modbus_slave_pkg::CRC_INIT, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // a stalled transmitter holds the answer builder, no byte is lost
  tx_skid_buf #(.W(8)) u_tx_buf (
    .mclk(mclk),
    .reset(reset),
    .in_valid(s_q.push),
    .in_ready(buf_in_ready),
    .in_data(s_q.txb),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  assign reg_rd = s_q.rd;
  assign reg_wr = s_q.wr;
  assign reg_setting = s_q.setting;
  assign reg_addr = s_q.raddr;
  assign reg_wdata = s_q.wdata;
  assign op_reset = s_q.op_rst;
  assign op_clear_events = s_q.op_evt;
  assign op_clear_oscillo = s_q.op_osc;
  assign virt_in = s_q.vin;
endmodule // modbus_slave_function_handler

//--- src/modbus_slave_pkg.sv
// constants, codes and the check-sum step shared by the function handler
package modbus_slave_pkg;
  // function codes
  localparam logic [7:0] FN_READ_HOLD = 8'h03;
  localparam logic [7:0] FN_READ_INPUT = 8'h04;
  localparam logic [7:0] FN_EXECUTE = 8'h05;
  localparam logic [7:0] FN_STORE_ONE = 8'h06;
  localparam logic [7:0] FN_STORE_MANY = 8'h10;
  // exception answers
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
  // register count limits
  localparam logic [15:0] MAX_READ_REGS = 16'h007d;
  localparam logic [15:0] MAX_STORE_REGS = 16'h003c;
  // operation codes and code values
  localparam logic [15:0] OP_NONE = 16'h0000;
  localparam logic [15:0] OP_RESET = 16'h0001;
  localparam logic [15:0] OP_CLEAR_EVENTS = 16'h0005;
  localparam logic [15:0] OP_CLEAR_OSCILLO = 16'h0006;
  localparam logic [15:0] OP_VIRT_FIRST = 16'h1000;
  localparam logic [15:0] OP_VIRT_LAST = 16'h101f;
  localparam logic [15:0] CODE_ON = 16'hff00;
  localparam logic [15:0] CODE_OFF = 16'h0000;
  // packet layout
  localparam logic [8:0] LEN_FIXED = 9'h008;
  localparam logic [8:0] LEN_STORE_HDR = 9'h009;
  localparam logic [8:0] LEN_MAX = 9'h100;
  localparam logic [7:0] POS_DATA_ONE = 8'h04;
  localparam logic [7:0] POS_DATA_MANY = 8'h07;
  localparam logic [2:0] HDR_SHORT = 3'h3;
  localparam logic [2:0] HDR_ECHO = 3'h6;
  // check-sum
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // timing: 3.5 byte times at 19200 bit/s, a least time so rounded up
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned GAP_US = 2000;
  localparam int unsigned GAP_CYCLES = (GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // default start of the setting space; below it lie actual values
  localparam logic [15:0] SETTING_BASE = 16'h4000;

  // one byte through the reflected check-sum, low bit first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] a;
    a = crc ^ {8'h00, b};
    for (int j = 0; j < 8; j++) begin
      a = a[0] ? ((a >> 1) ^ CRC_POLY) : (a >> 1);
    end
    return a;
  endfunction
endpackage

//--- src/tx_skid_buf.sv
// two-entry byte buffer between the answer builder and the transmitter
module tx_skid_buf #(
  parameter int unsigned W = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
  } buf_state_t;

  buf_state_t s_q, s_d;

  always_comb begin
    logic pop;
    logic push;
    logic [1:0] c;
    pop = s_q.vld && out_ready;
    push = in_valid && s_q.rdy;
    s_d = s_q;
    c = s_q.cnt;
    if (pop) begin
      s_d.mem[0] = s_q.mem[1];
      c = c - 2'h1;
    end
    if (push) begin
      s_d.mem[c[0]] = in_data;
      c = c + 2'h1;
    end
    s_d.cnt = c;
    s_d.vld = (c != 2'h0);
    s_d.rdy = (c != 2'h2);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '{mem: '0, cnt: 2'h0, vld: 1'b0, rdy: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.rdy;
  assign out_valid = s_q.vld;
  assign out_data = s_q.mem[0];
endmodule // tx_skid_buf

//--- tb/modbus_master_model.sv
// far side: register read source and a byte sink that stalls
module modbus_master_model (
  input wire logic mclk,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  output logic [15:0] reg_rdata,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;
  logic rd_d = 1'b0;
  initial reg_rdata = 16'h0000;
  initial tx_ready = 1'b0;
  // data stands two cycles after the strobe, scrambled after so a late sample shows
  always @(negedge mclk) begin
    rd_d <= reg_rd;
    reg_rdata <= reg_rd ? (reg_addr ^ 16'h5a5a) : (rd_d ? reg_rdata : ~reg_rdata);
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tx_ready <= (ph != 2'h0);
  end
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule // modbus_master_model

//--- tb/modbus_slave_checker.sv
// port checks for the function handler
module modbus_slave_checker #(
  parameter int unsigned GAP_CYCLES = 20,
  parameter logic [15:0] SETTING_BASE = 16'h4000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_setting,
  input wire logic [15:0] reg_addr,
  input wire logic op_reset,
  input wire logic op_clear_events,
  input wire logic op_clear_oscillo,
  input wire logic [31:0] virt_in
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  int unsigned idle_q;
  logic any_op;
  assign any_op = op_reset | op_clear_events | op_clear_oscillo;
  // saturates so a long idle never wraps
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) idle_q <= 0;
    else if (rx_valid) idle_q <= 0;
    else if (idle_q < GAP_CYCLES) idle_q <= idle_q + 1;
  end
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_two_writes;
    reg_wr ##1 reg_wr;
  endsequence
  a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
    else $error("byte changed in stall");
  a_setting_split: assert property (
    (reg_rd || reg_wr) |-> reg_setting == (reg_addr >= SETTING_BASE))
    else $error("data kind wrong");
  a_read_spacing: assert property (reg_rd |=> !reg_rd [*3])
    else $error("reads too close");
  a_write_rising: assert property (s_two_writes |-> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("write address not rising");
  a_op_single: assert property (
    any_op |-> $onehot({op_reset, op_clear_events, op_clear_oscillo}) ##1 !any_op)
    else $error("operation pulse wrong");
  a_answer_gap: assert property ($rose(tx_valid) |-> idle_q >= GAP_CYCLES)
    else $error("answer before frame end");
  a_strobe_gap: assert property ((reg_wr || any_op) |-> idle_q >= GAP_CYCLES)
    else $error("action before frame check");
  a_virt_one: assert property ($changed(virt_in) |-> $onehot(virt_in ^ $past(virt_in)))
    else $error("several inputs changed");
endmodule // modbus_slave_checker

//--- tb/modbus_slave_function_handler_tb.sv
// self-checking bench for the function handler
module modbus_slave_function_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned GAP = 20;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] own_address = 8'h11;
  logic tx_valid, tx_ready, reg_rd, reg_wr, reg_setting;
  logic op_reset, op_clear_events, op_clear_oscillo;
  logic [7:0] tx_data;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, wa, wd;
  logic [31:0] virt_in;
  logic rs;
  logic [7:0] req[$];
  logic [7:0] exp[$];
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int nwr = 0;
  int nop[3] = '{0, 0, 0};
  always #5 mclk = ~mclk;
  modbus_slave_function_handler #(.GAP_CYCLES(GAP)) dut_u (
    .mclk(mclk), .reset(reset), .own_address(own_address), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_setting(reg_setting), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_reset(op_reset),
    .op_clear_events(op_clear_events), .op_clear_oscillo(op_clear_oscillo), .virt_in(virt_in));
  modbus_master_model mst_u (.mclk(mclk), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  always @(posedge mclk) begin
    cyc++;
    nop[0] += op_reset;
    nop[1] += op_clear_events;
    nop[2] += op_clear_oscillo;
    if (reg_rd || reg_wr) rs = reg_setting;
    if (reg_wr) begin
      nwr++;
      wa = reg_addr;
      wd = reg_wdata;
    end
    if (cyc == 30000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  // sends req with its check-sum, then judges the whole answer against exp
  task automatic xfer(input logic bad);
    logic [15:0] c;
    int w;
    c = crc_of(req) ^ {15'h0000, bad};
    req = {req, c[7:0], c[15:8]};
    mst_u.got.delete();
    foreach (req[i]) begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_data = req[i];
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    c = crc_of(exp);
    if (exp.size() > 0) exp = {exp, c[7:0], c[15:8]};
    w = 0;
    while (mst_u.got.size() < exp.size() && w < 1500) begin
      @(negedge mclk);
      w++;
    end
    // extra bytes would land in this margin
    repeat (GAP + 40) @(negedge mclk);
    chk(mst_u.got.size(), exp.size());
    foreach (exp[i]) if (i < mst_u.got.size()) chk({8'h00, mst_u.got[i]}, {8'h00, exp[i]});
    req.delete();
    exp.delete();
  endtask
  task automatic rd(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] n);
    logic [15:0] d;
    req = {8'h11, fn, a[15:8], a[7:0], n[15:8], n[7:0]};
    exp = {8'h11, fn, 8'(2 * n)};
    if (n == 16'h0000 || n > 16'h007d) exp = {8'h11, fn | 8'h80, 8'h03};
    else for (int k = 0; k < int'(n); k++) begin
      d = (a + 16'(k)) ^ 16'h5a5a;
      exp = {exp, d[15:8], d[7:0]};
    end
    xfer(1'b0);
  endtask
  task automatic ex(input logic [15:0] op, input logic [15:0] cv, input logic [7:0] e);
    req = {8'h11, 8'h05, op[15:8], op[7:0], cv[15:8], cv[7:0]};
    if (e == 8'h00) exp = req;
    else exp = {8'h11, 8'h85, e};
    xfer(1'b0);
  endtask
  task automatic stm(input logic [15:0] n, input logic [7:0] bc, input int mode);
    req = {8'h11, 8'h10, 8'h40, 8'h51, n[15:8], n[7:0], bc};
    for (int k = 0; k < int'(bc) / 2; k++) req = {req, 8'h00, 8'(k + 1)};
    if (mode == 0) exp = req[0:5];
    else if (mode == 1) exp = {8'h11, 8'h90, 8'h03};
    xfer(1'b0);
  endtask
  task automatic t_read();
    rd(8'h03, 16'h4050, 16'h0003);
    rd(8'h04, 16'h4050, 16'h0003);
    chk(rs, 32'h0000_0001);
    rd(8'h04, 16'h0000, 16'h007d);
    chk(rs, 32'h0000_0000);
    rd(8'h03, 16'h4050, 16'h007e);
    rd(8'h04, 16'h4050, 16'h0000);
  endtask
  task automatic t_exec();
    logic [15:0] ops[6] = '{16'h0000, 16'h0001, 16'h0005, 16'h0006, 16'h1000, 16'h101f};
    foreach (ops[i]) ex(ops[i], 16'hff00, 8'h00);
    chk(virt_in, 32'h8000_0001);
    ex(16'h1000, 16'h0000, 8'h00);
    chk(virt_in, 32'h8000_0000);
    ex(16'h0002, 16'hff00, 8'h02);
    ex(16'h0001, 16'h1234, 8'h03);
    chk({nop[2] == 1, nop[1] == 1, nop[0] == 1}, 32'h0000_0007);
  endtask
  task automatic t_store();
    req = {8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hc8};
    exp = req;
    xfer(1'b0);
    chk({wa, wd}, 32'h4051_00c8);
    chk(rs, 32'h0000_0001);
    stm(16'h0002, 8'h04, 0);
    chk({wa, wd}, 32'h4052_0002);
    stm(16'h003c, 8'h78, 0);
    chk({wa, wd}, 32'h408c_003c);
    stm(16'h003d, 8'h7a, 1);
    stm(16'h0002, 8'h06, 2);
    chk(nwr, 32'h0000_003f);
  endtask
  task automatic t_refuse();
    logic [7:0] bad[4] = '{8'h39, 8'h01, 8'h11, 8'h7f};
    req = {8'h12, 8'h03, 8'h40, 8'h50, 8'h00, 8'h01};
    xfer(1'b0);
    req = {8'h11, 8'h03, 8'h40, 8'h50, 8'h00, 8'h01};
    xfer(1'b1);
    req = {8'h11, 8'h03, 8'h40, 8'h50, 8'h00, 8'h01, 8'h00};
    xfer(1'b0);
    foreach (bad[i]) begin
      req = {8'h11, bad[i]};
      exp = {8'h11, bad[i] | 8'h80, 8'h01};
      xfer(1'b0);
    end
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    t_read();
    t_exec();
    t_store();
    t_refuse();
    conclude();
  end
endmodule // modbus_slave_function_handler_tb

bind modbus_slave_function_handler modbus_slave_checker #(.GAP_CYCLES(GAP_CYCLES),
  .SETTING_BASE(SETTING_BASE)) chk_u (.mclk(mclk), .reset(reset), .rx_valid(rx_valid),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_setting(reg_setting), .reg_addr(reg_addr), .op_reset(op_reset),
  .op_clear_events(op_clear_events), .op_clear_oscillo(op_clear_oscillo), .virt_in(virt_in));
